// File: rtl/tsf_pkg.sv
/*
 * Package for the transceiver status-flag block: operating modes, the
 * flag vector layout, pin bundles and timing counts.
 * Assumes a 40 MHz system clock; times are kept in microseconds.
 */
package tsf_pkg;

	typedef enum logic [2:0] {
		TSF_MODE_SLEEP,
		TSF_MODE_STANDBY,
		TSF_MODE_GOSLEEP,
		TSF_MODE_SILENT,
		TSF_MODE_NORMAL
	} tsf_mode_t;

	localparam int CLK_MHZ                = 40;
	localparam int DOMINANT_TIMEOUT_US    = 1200;
	localparam int BUS_DOMINANT_US        = 1400;
	localparam int UV_FILTER_US           = 100;
	localparam int DOMINANT_TIMEOUT_CYC   = DOMINANT_TIMEOUT_US * CLK_MHZ;
	localparam int BUS_DOMINANT_CYC       = BUS_DOMINANT_US * CLK_MHZ;
	localparam int UV_FILTER_CYC          = UV_FILTER_US * CLK_MHZ;
	localparam int TIMER_W                = 20;
	localparam int EDGE_COUNT             = 4;
	localparam logic [2:0] EDGE_LAST      = 3'h3;

	// analog comparator and detector levels, synchronised inside tsf_status_flags
	typedef struct packed {
		logic core_low;
		logic io_low;
		logic battery_low;
		logic over_temp;
		logic bus_fault_seen;
		logic local_wake;
		logic remote_wake;
	} tsf_sense_t;

	// flag vector seen from outside
	typedef struct packed {
		logic cold_start_flag;
		logic wake_request_flag;
		logic wake_source_flag;
		logic core_supply_low_flag;
		logic io_supply_low_flag;
		logic battery_supply_low_flag;
		logic bus_fault_flag;
		logic dominant_timeout_flag;
		logic transmit_receive_short_flag;
		logic bus_stuck_dominant_flag;
		logic thermal_shutdown_flag;
	} tsf_flags_t;

	localparam tsf_flags_t FLAGS_RESET = '0;

endpackage

// File: rtl/tsf_timer.sv
/*
 * Persistence timer: counts cycles while a condition holds and raises
 * expired once the count reaches the limit.
 * Assumes cond is already synchronous to clk.
 */
`timescale 1ns/1ps
module tsf_timer #(
	parameter int LIMIT = 16
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic cond,
	input  wire logic restart,
	output logic      expired
);
	logic [tsf_pkg::TIMER_W-1:0] count_r;

	always_ff @(posedge clk) begin
		if (!rst_n || !cond || restart) begin
			count_r <= '0;
		end else if (count_r != tsf_pkg::TIMER_W'(LIMIT)) begin
			count_r <= count_r + 1'b1;
		end
	end

	assign expired = cond && (count_r == tsf_pkg::TIMER_W'(LIMIT));
endmodule

// File: rtl/tsf_status_flags.sv
/*
 * Status-flag logic of a CAN FD transceiver: sticky flags, driver gating,
 * fault and receive indicator pins.
 * Assumes mode and pins are synchronous to clk (comparator levels are synchronised here) and
 * rst_n comes from loss of the main supply.
 */
// Overview of operation
// RQ1: core/io low flags set on supply drop, cleared on recovery or wake request.
// RQ2: battery low flag follows battery supply; recovery counts as cold start.
// RQ3: bus fault flag after four faulty transmit rising edges; indicated in normal only.
// RQ4: bus fault flag clears leaving normal or after four clean edges.
// RQ5: dominant timeout flag on long low transmit; shown entering silent from normal.
// RQ6: driver off during dominant timeout; cleared by pin or mode conditions.
// RQ7: transmit/receive short sets flag after timeout; driver off until cleared.
// RQ8: bus stuck dominant flag after long dominant receive; driver stays enabled.
// RQ9: thermal flag disables driver; clears when cool plus pins, or on entering normal, standby, go-to-sleep or sleep.
// RQ10: go-to-sleep transition blocked while wake request flag set.
// RQ11: wake source flag records only the first wake source.
// RQ12: wake source shown only in normal mode until cleared.
// RQ13: cold start flag set whenever battery supply rises above threshold.
// RQ14: cold start shown entering silent from standby/sleep; cleared in normal.
// RQ15: wake request only set in standby, go-to-sleep or sleep.
// RQ16: wake request setting restarts undervoltage filter timer.
// RQ17: wake request cleared on normal entry or core/io undervoltage.
// RQ18: faults ORed onto active-low fault pin; receive pin shows wake request in standby, go-to-sleep and sleep.
// RQ19: both pins low in standby while wake request set.
// RQ20: flags sticky in one clock domain; comparator inputs synchronised first.
`timescale 1ns/1ps
module tsf_status_flags #(
	parameter int DOMINANT_TIMEOUT_CYC = tsf_pkg::DOMINANT_TIMEOUT_CYC,
	parameter int BUS_DOMINANT_CYC     = tsf_pkg::BUS_DOMINANT_CYC,
	parameter int UV_FILTER_CYC        = tsf_pkg::UV_FILTER_CYC
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  tsf_pkg::tsf_mode_t      mode_req,
	input  wire logic               txd,
	input  wire logic               bus_rx,
	input  tsf_pkg::tsf_sense_t     sense_async,
	output tsf_pkg::tsf_mode_t      mode,
	output logic                    driver_enable,
	output logic                    fault_indicator_n,
	output logic                    rxd,
	output tsf_pkg::tsf_flags_t     flags
);
	tsf_pkg::tsf_sense_t s1_r;
	tsf_pkg::tsf_sense_t s_r;
	tsf_pkg::tsf_mode_t  mode_r;
	tsf_pkg::tsf_mode_t  mode_nxt;
	tsf_pkg::tsf_mode_t  prev_mode_r;
	logic                txd_d_r;
	logic                rxd_d_r;
	logic                battery_low_d_r;
	logic                txd_rise;
	logic                rxd_rise;
	logic                mode_change;
	logic                into_normal_sbsl;
	logic                leave_normal;
	logic                silent_from_normal_r;
	logic                silent_from_low_r;
	logic                rxd_r;
	logic                fault_n_r;
	logic                cold_start_r;
	logic                wake_req_r;
	logic                wake_src_local_r;
	logic                wake_src_valid_r;
	logic                core_low_r;
	logic                io_low_r;
	logic                bat_low_r;
	logic                bus_fault_r;
	logic [2:0]          fault_edges_r;
	logic [2:0]          clean_edges_r;
	logic                dto_r;
	logic                short_r;
	logic                busdom_r;
	logic                tsd_r;
	logic                wake_set;
	logic                battery_rise;
	logic                dto_hit;
	logic                short_hit;
	logic                busdom_hit;
	logic                core_uv_hit;
	logic                io_uv_hit;
	localparam logic [2:0] EDGE_LAST_C = tsf_pkg::EDGE_LAST;

	function automatic logic low_power(input tsf_pkg::tsf_mode_t m);
		low_power = (m == tsf_pkg::TSF_MODE_STANDBY) || (m == tsf_pkg::TSF_MODE_GOSLEEP) ||
			(m == tsf_pkg::TSF_MODE_SLEEP);
	endfunction

	function automatic logic clearing_mode(input tsf_pkg::tsf_mode_t m);
		clearing_mode = low_power(m) || (m == tsf_pkg::TSF_MODE_NORMAL);
	endfunction

	// two-stage input synchroniser
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_r <= '0;
			s_r  <= '0;
		end else begin
			s1_r <= sense_async; // RQ20
			s_r  <= s1_r; // RQ20
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txd_d_r         <= 1'b1;
			rxd_d_r         <= 1'b1;
			battery_low_d_r <= 1'b1;
		end else begin
			txd_d_r         <= txd;
			rxd_d_r         <= bus_rx;
			battery_low_d_r <= s_r.battery_low;
		end
	end

	assign txd_rise     = txd && !txd_d_r;
	assign rxd_rise     = bus_rx && !rxd_d_r;
	assign battery_rise = battery_low_d_r && !s_r.battery_low;

	// mode tracking with go-to-sleep blocked during a wake request
	always_comb begin
		mode_nxt = mode_req;
		if (mode_req == tsf_pkg::TSF_MODE_GOSLEEP && wake_req_r) begin
			mode_nxt = mode_r; // RQ10
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_r      <= tsf_pkg::TSF_MODE_STANDBY;
			prev_mode_r <= tsf_pkg::TSF_MODE_STANDBY;
		end else begin
			mode_r <= mode_nxt;
			if (mode_nxt != mode_r) begin
				prev_mode_r <= mode_r;
			end
		end
	end

	assign mode_change      = mode_nxt != mode_r;
	assign into_normal_sbsl = mode_change && clearing_mode(mode_nxt);
	assign leave_normal     = mode_change && mode_r == tsf_pkg::TSF_MODE_NORMAL;

	// how silent mode was entered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			silent_from_normal_r <= 1'b0;
			silent_from_low_r    <= 1'b0;
		end else if (mode_change) begin
			silent_from_normal_r <= mode_nxt == tsf_pkg::TSF_MODE_SILENT &&
				mode_r == tsf_pkg::TSF_MODE_NORMAL;
			silent_from_low_r    <= mode_nxt == tsf_pkg::TSF_MODE_SILENT &&
				(mode_r == tsf_pkg::TSF_MODE_STANDBY || mode_r == tsf_pkg::TSF_MODE_SLEEP);
		end
	end

	tsf_timer #(.LIMIT(DOMINANT_TIMEOUT_CYC)) u_dto (
		.clk     (clk),
		.rst_n   (rst_n),
		.cond    (!txd),
		.restart (1'b0),
		.expired (dto_hit)
	);

	tsf_timer #(.LIMIT(DOMINANT_TIMEOUT_CYC)) u_short (
		.clk     (clk),
		.rst_n   (rst_n),
		.cond    (!txd && !bus_rx && !driver_enable),
		.restart (1'b0),
		.expired (short_hit)
	);

	tsf_timer #(.LIMIT(BUS_DOMINANT_CYC)) u_busdom (
		.clk     (clk),
		.rst_n   (rst_n),
		.cond    (!bus_rx),
		.restart (1'b0),
		.expired (busdom_hit)
	);

	tsf_timer #(.LIMIT(UV_FILTER_CYC)) u_uv_core (
		.clk     (clk),
		.rst_n   (rst_n),
		.cond    (s_r.core_low),
		.restart (wake_set), // RQ16
		.expired (core_uv_hit)
	);

	tsf_timer #(.LIMIT(UV_FILTER_CYC)) u_uv_io (
		.clk     (clk),
		.rst_n   (rst_n),
		.cond    (s_r.io_low),
		.restart (wake_set), // RQ16
		.expired (io_uv_hit)
	);

	// supply flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core_low_r <= 1'b0;
			io_low_r   <= 1'b0;
			bat_low_r  <= 1'b0;
		end else begin
			if (core_uv_hit) begin
				core_low_r <= 1'b1; // RQ1
			end else if (!s_r.core_low || wake_set) begin
				core_low_r <= 1'b0; // RQ1
			end
			if (io_uv_hit) begin
				io_low_r <= 1'b1; // RQ1
			end else if (!s_r.io_low || wake_set) begin
				io_low_r <= 1'b0; // RQ1
			end
			bat_low_r <= s_r.battery_low; // RQ2
		end
	end

	// cold start flag; reset itself is a battery power-up
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cold_start_r <= 1'b1;
		end else if (battery_rise) begin
			cold_start_r <= 1'b1; // RQ13 RQ2
		end else if (mode_change && mode_nxt == tsf_pkg::TSF_MODE_NORMAL) begin
			cold_start_r <= 1'b0; // RQ14
		end
	end

	assign wake_set = low_power(mode_r) &&
		(s_r.local_wake || s_r.remote_wake || battery_rise); // RQ15

	// wake request: set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wake_req_r <= 1'b1;
		end else if (wake_set) begin
			wake_req_r <= 1'b1; // RQ15
		end else if ((mode_change && mode_nxt == tsf_pkg::TSF_MODE_NORMAL) ||
				core_uv_hit || io_uv_hit) begin
			wake_req_r <= 1'b0; // RQ17
		end
	end

	// wake source keeps the first source only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wake_src_valid_r <= 1'b1;
			wake_src_local_r <= 1'b1;
		end else if (wake_set && !wake_src_valid_r) begin
			wake_src_valid_r <= 1'b1; // RQ11
			wake_src_local_r <= s_r.local_wake || battery_rise;
		end else if (leave_normal || core_uv_hit || io_uv_hit ||
				(mode_r == tsf_pkg::TSF_MODE_NORMAL && txd_rise && clean_edges_r == EDGE_LAST_C)) begin
			wake_src_valid_r <= 1'b0;
		end
	end

	// bus fault edge counting in normal mode
	always_ff @(posedge clk) begin
		if (!rst_n || mode_r != tsf_pkg::TSF_MODE_NORMAL) begin
			fault_edges_r <= '0;
			clean_edges_r <= '0;
			bus_fault_r   <= 1'b0; // RQ4
		end else if (txd_rise) begin
			if (s_r.bus_fault_seen) begin
				clean_edges_r <= '0;
				if (fault_edges_r == EDGE_LAST_C) begin
					bus_fault_r <= 1'b1; // RQ3
				end else begin
					fault_edges_r <= fault_edges_r + 3'h1;
				end
			end else begin
				fault_edges_r <= '0;
				if (clean_edges_r == EDGE_LAST_C) begin
					bus_fault_r   <= 1'b0; // RQ4
					clean_edges_r <= '0;
				end else begin
					clean_edges_r <= clean_edges_r + 3'h1;
				end
			end
		end
	end

	// local faults; set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dto_r    <= 1'b0;
			short_r  <= 1'b0;
			busdom_r <= 1'b0;
			tsd_r    <= 1'b0;
		end else begin
			if (dto_hit) begin
				dto_r <= 1'b1; // RQ5
			end else if ((txd && !bus_rx) || (txd && into_normal_sbsl)) begin
				dto_r <= 1'b0; // RQ6
			end
			if (short_hit) begin
				short_r <= 1'b1; // RQ7
			end else if ((txd_rise && !bus_rx) || into_normal_sbsl) begin
				short_r <= 1'b0; // RQ7
			end
			if (busdom_hit) begin
				busdom_r <= 1'b1; // RQ8
			end else if (rxd_rise || bus_rx || into_normal_sbsl) begin
				busdom_r <= 1'b0; // RQ8
			end
			if (s_r.over_temp) begin
				tsd_r <= 1'b1; // RQ9
			end else if ((!bus_rx && txd) || into_normal_sbsl) begin
				tsd_r <= 1'b0; // RQ9
			end
		end
	end

	// driver gating; stuck dominant leaves it on
	assign driver_enable = !dto_r && !short_r && !tsd_r &&
		(mode_r == tsf_pkg::TSF_MODE_NORMAL); // RQ6 RQ7 RQ9 RQ8

	// indicator pins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fault_n_r <= 1'b1;
			rxd_r     <= 1'b1;
		end else begin
			case (mode_r)
				tsf_pkg::TSF_MODE_NORMAL: begin
					fault_n_r <= !(bus_fault_r || tsd_r || // RQ3 RQ18
						(wake_src_valid_r && wake_src_local_r)); // RQ12
					rxd_r     <= bus_rx;
				end
				tsf_pkg::TSF_MODE_SILENT: begin
					fault_n_r <= !((silent_from_normal_r && (dto_r || short_r || busdom_r)) || // RQ5
						(silent_from_low_r && cold_start_r) || tsd_r); // RQ14 RQ18
					rxd_r     <= bus_rx;
				end
				tsf_pkg::TSF_MODE_STANDBY, tsf_pkg::TSF_MODE_GOSLEEP,
				tsf_pkg::TSF_MODE_SLEEP: begin
					fault_n_r <= !wake_req_r; // RQ19
					rxd_r     <= !wake_req_r; // RQ18 RQ19
				end
				default: begin
					fault_n_r <= 1'b1;
					rxd_r     <= 1'b1;
				end
			endcase
		end
	end

	assign fault_indicator_n = fault_n_r;
	assign rxd               = rxd_r;
	assign mode              = mode_r;

	assign flags = '{
		cold_start_flag:             cold_start_r,
		wake_request_flag:           wake_req_r,
		wake_source_flag:            wake_src_valid_r && wake_src_local_r,
		core_supply_low_flag:        core_low_r,
		io_supply_low_flag:          io_low_r,
		battery_supply_low_flag:     bat_low_r,
		bus_fault_flag:              bus_fault_r,
		dominant_timeout_flag:       dto_r,
		transmit_receive_short_flag: short_r,
		bus_stuck_dominant_flag:     busdom_r,
		thermal_shutdown_flag:       tsd_r
	};

	logic unused_prev;
	assign unused_prev = ^prev_mode_r;
endmodule

// File: verification/tsf_status_flags_asserts.sv
/*
 * Checker for the status-flag block: relations between mode, flags and pins.
 * Assumes it is bound to tsf_status_flags and sees only its ports.
 */
`timescale 1ns/1ps
module tsf_status_flags_asserts (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  tsf_pkg::tsf_mode_t  mode,
	input  wire logic           driver_enable,
	input  wire logic           fault_indicator_n,
	input  wire logic           rxd,
	input  tsf_pkg::tsf_flags_t flags
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_gosleep_blocked: assert property (mode != tsf_pkg::TSF_MODE_GOSLEEP
		&& flags.wake_request_flag |=> mode != tsf_pkg::TSF_MODE_GOSLEEP)
		else $error("go-to-sleep entered with wake request");
	a_wake_pins_low: assert property ((mode == tsf_pkg::TSF_MODE_STANDBY
		&& flags.wake_request_flag) [*2] |-> !rxd && !fault_indicator_n)
		else $error("wake request not shown on pins");
	a_bus_fault_pin: assert property ((mode == tsf_pkg::TSF_MODE_NORMAL
		&& flags.bus_fault_flag) [*2] |-> !fault_indicator_n)
		else $error("bus fault not shown on fault pin");
	a_bus_fault_leave: assert property ((mode != tsf_pkg::TSF_MODE_NORMAL) [*2]
		|-> !flags.bus_fault_flag)
		else $error("bus fault kept outside normal mode");
	a_wake_set_idle: assert property ($rose(flags.wake_request_flag)
		|-> $past(mode) inside {tsf_pkg::TSF_MODE_STANDBY, tsf_pkg::TSF_MODE_GOSLEEP,
		tsf_pkg::TSF_MODE_SLEEP})
		else $error("wake request set in active mode");
	a_normal_clears: assert property ((mode == tsf_pkg::TSF_MODE_NORMAL) [*3]
		|-> !flags.cold_start_flag && !flags.wake_request_flag)
		else $error("cold start or wake request kept in normal mode");
	a_uv_drops_wake: assert property ($rose(flags.core_supply_low_flag
		| flags.io_supply_low_flag) |-> ##[0:2] !flags.wake_request_flag)
		else $error("wake request kept after undervoltage");
	a_driver_gated: assert property (flags.dominant_timeout_flag
		|| flags.transmit_receive_short_flag || flags.thermal_shutdown_flag |-> !driver_enable)
		else $error("driver enabled during local fault");
	a_stuck_driver_on: assert property (mode == tsf_pkg::TSF_MODE_NORMAL
		&& flags.bus_stuck_dominant_flag && !flags.dominant_timeout_flag
		&& !flags.transmit_receive_short_flag && !flags.thermal_shutdown_flag
		|-> driver_enable)
		else $error("driver off during stuck dominant bus");
	a_cold_on_battery: assert property ($fell(flags.battery_supply_low_flag)
		|-> ##[0:1] flags.cold_start_flag)
		else $error("no cold start after battery recovery");
endmodule

bind tsf_status_flags tsf_status_flags_asserts tsf_status_flags_asserts_inst (
	.clk               (clk),
	.rst_n             (rst_n),
	.mode              (mode),
	.driver_enable     (driver_enable),
	.fault_indicator_n (fault_indicator_n),
	.rxd               (rxd),
	.flags             (flags)
);

// File: verification/tsf_ctrl_model.sv
/*
 * Controller-side model: sends dominant bits on the transmit pin.
 * Assumes send is raised for one cycle while busy is low.
 */
`timescale 1ns/1ps
module tsf_ctrl_model (
	input  wire logic       clk,
	input  wire logic       send,
	input  wire logic       hold_dom,
	input  wire logic [3:0] bits_n,
	output logic            txd,
	output logic            busy
);
	logic [3:0] left_r = 4'h0;
	logic [1:0] ph_r   = 2'h0;

	// two cycles dominant, two recessive per bit
	always_ff @(posedge clk) begin
		if (send && left_r == 4'h0) begin
			left_r <= bits_n;
			ph_r   <= 2'h0;
		end else if (left_r != 4'h0) begin
			ph_r <= ph_r + 2'h1;
			if (ph_r == 2'h3) begin
				left_r <= left_r - 4'h1;
			end
		end
	end
	assign busy = left_r != 4'h0;
	assign txd  = ~(hold_dom | (busy & ~ph_r[1]));
endmodule

// File: verification/tb_tsf_status_flags.sv
/*
 * Self-checking bench for tsf_status_flags with short timing counts.
 * Assumes tsf_ctrl_model drives the transmit pin; the bus is modelled here.
 */
`timescale 1ns/1ps
module tb_tsf_status_flags;
	logic                clk        = 1'b0;
	logic                rst_n      = 1'b0;
	tsf_pkg::tsf_mode_t  mode_req   = tsf_pkg::TSF_MODE_STANDBY;
	logic                send       = 1'b0;
	logic                hold_dom   = 1'b0;
	logic                rx_force_n = 1'b1;
	tsf_pkg::tsf_sense_t sense      = '0;
	logic                busy;
	logic                txd;
	logic                bus_rx;
	tsf_pkg::tsf_mode_t  mode;
	logic                driver_enable;
	logic                fault_indicator_n;
	logic                rxd;
	tsf_pkg::tsf_flags_t flags;
	int                  errors     = 0;
	int                  compares   = 0;
	int                  cycles     = 0;

	always #12.5 clk = ~clk;
	// bus dominant when driven or forced by another node
	assign bus_rx = rx_force_n & (txd | ~driver_enable);

	tsf_ctrl_model tsf_ctrl_model_inst (.clk(clk), .send(send), .hold_dom(hold_dom),
		.bits_n(4'h4), .txd(txd), .busy(busy));
	tsf_status_flags #(.DOMINANT_TIMEOUT_CYC(20), .BUS_DOMINANT_CYC(30), .UV_FILTER_CYC(10))
		tsf_status_flags_inst (.clk(clk), .rst_n(rst_n), .mode_req(mode_req), .txd(txd),
		.bus_rx(bus_rx), .sense_async(sense), .mode(mode), .driver_enable(driver_enable),
		.fault_indicator_n(fault_indicator_n), .rxd(rxd), .flags(flags));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			stop_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_mode(input tsf_pkg::tsf_mode_t exp, input tsf_pkg::tsf_mode_t got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR mode expected %0d seen %0d", exp, got);
		end
	endtask
	task automatic set_mode(input tsf_pkg::tsf_mode_t m);
		mode_req = m;
		cyc(3);
	endtask
	// four transmit bits, bus fault seen or not
	task automatic edges(input logic seen);
		int n;
		n = 0;
		sense.bus_fault_seen = seen;
		cyc(3);
		send = 1'b1;
		cyc(1);
		send = 1'b0;
		while (busy && n < 100) begin
			cyc(1);
			n++;
		end
		cyc(2);
	endtask

	task automatic t_reset();
		chk_mode(tsf_pkg::TSF_MODE_STANDBY, mode);
		chk_bit("cold", 1'b1, flags.cold_start_flag);
		chk_bit("wake", 1'b1, flags.wake_request_flag);
		rst_n = 1'b1;
		cyc(2);
		chk_bit("rxd", 1'b0, rxd);
		chk_bit("fault_n", 1'b0, fault_indicator_n);
		set_mode(tsf_pkg::TSF_MODE_GOSLEEP);
		chk_mode(tsf_pkg::TSF_MODE_STANDBY, mode);
	endtask
	task automatic t_normal();
		set_mode(tsf_pkg::TSF_MODE_NORMAL);
		chk_bit("cold", 1'b0, flags.cold_start_flag);
		chk_bit("wake", 1'b0, flags.wake_request_flag);
		chk_bit("fault_n", 1'b0, fault_indicator_n);
		edges(1'b0);
		chk_bit("fault_n", 1'b1, fault_indicator_n);
		edges(1'b1);
		chk_bit("bus_fault", 1'b1, flags.bus_fault_flag);
		chk_bit("fault_n", 1'b0, fault_indicator_n);
		edges(1'b0);
		chk_bit("bus_fault", 1'b0, flags.bus_fault_flag);
		chk_bit("fault_n", 1'b1, fault_indicator_n);
	endtask
	task automatic t_dto();
		hold_dom = 1'b1;
		cyc(25);
		chk_bit("dto", 1'b1, flags.dominant_timeout_flag);
		chk_bit("driver", 1'b0, driver_enable);
		set_mode(tsf_pkg::TSF_MODE_SILENT);
		chk_bit("fault_n", 1'b0, fault_indicator_n);
		hold_dom = 1'b0;
		rx_force_n = 1'b0;
		cyc(3);
		chk_bit("dto", 1'b0, flags.dominant_timeout_flag);
		hold_dom = 1'b1;
		cyc(25);
		chk_bit("short", 1'b1, flags.transmit_receive_short_flag);
		hold_dom = 1'b0;
		cyc(3);
		chk_bit("short", 1'b0, flags.transmit_receive_short_flag);
		rx_force_n = 1'b1;
	endtask
	task automatic t_stuck_thermal();
		set_mode(tsf_pkg::TSF_MODE_NORMAL);
		rx_force_n = 1'b0;
		cyc(35);
		chk_bit("stuck", 1'b1, flags.bus_stuck_dominant_flag);
		chk_bit("driver", 1'b1, driver_enable);
		rx_force_n = 1'b1;
		cyc(3);
		chk_bit("stuck", 1'b0, flags.bus_stuck_dominant_flag);
		sense.over_temp = 1'b1;
		cyc(6);
		chk_bit("thermal", 1'b1, flags.thermal_shutdown_flag);
		chk_bit("driver", 1'b0, driver_enable);
		sense.over_temp = 1'b0;
		cyc(3);
		set_mode(tsf_pkg::TSF_MODE_STANDBY);
		chk_bit("thermal", 1'b0, flags.thermal_shutdown_flag);
	endtask
	task automatic t_wake_supply();
		set_mode(tsf_pkg::TSF_MODE_GOSLEEP);
		chk_mode(tsf_pkg::TSF_MODE_GOSLEEP, mode);
		sense.local_wake = 1'b1;
		cyc(4);
		chk_bit("wake", 1'b1, flags.wake_request_flag);
		chk_bit("wake_src", 1'b1, flags.wake_source_flag);
		sense.local_wake = 1'b0;
		sense.remote_wake = 1'b1;
		set_mode(tsf_pkg::TSF_MODE_STANDBY);
		sense.remote_wake = 1'b0;
		chk_bit("wake_src", 1'b1, flags.wake_source_flag);
		chk_bit("rxd", 1'b0, rxd);
		chk_bit("fault_n", 1'b0, fault_indicator_n);
		sense.core_low = 1'b1;
		cyc(15);
		chk_bit("core_low", 1'b1, flags.core_supply_low_flag);
		chk_bit("wake", 1'b0, flags.wake_request_flag);
		sense.core_low = 1'b0;
		sense.battery_low = 1'b1;
		cyc(5);
		chk_bit("core_low", 1'b0, flags.core_supply_low_flag);
		chk_bit("batt_low", 1'b1, flags.battery_supply_low_flag);
		sense.battery_low = 1'b0;
		cyc(5);
		chk_bit("batt_low", 1'b0, flags.battery_supply_low_flag);
		chk_bit("cold", 1'b1, flags.cold_start_flag);
	endtask

	initial begin
		cyc(20);
		t_reset();
		t_normal();
		t_dto();
		t_stuck_thermal();
		t_wake_supply();
		stop_test();
	end
endmodule
